//--- rtl/igm_pkg.sv
// constants for the interrupt and general-input monitor block
// assumes a single 250 mhz system clock and an 8-bit internal register port
package igm_pkg;
  // register offsets
  localparam logic [7:0] IGM_ADDR_LEVELS = 8'h2f;
  localparam logic [7:0] IGM_ADDR_CFG = 8'h32;
  localparam logic [7:0] IGM_ADDR_MASK = 8'h33;
  localparam logic [7:0] IGM_ADDR_LATCH = 8'h36;
  // reset values
  localparam logic [7:0] IGM_MASK_RESET = 8'hff;
  localparam logic [7:0] IGM_ZERO_WORD = 8'h00;
  // field positions
  localparam int IGM_BIT_POL = 7;
  localparam int IGM_BIT_MODE_HI = 6;
  localparam int IGM_BIT_MODE_LO = 5;
  localparam int IGM_BIT_RDSEL = 2;
  localparam int IGM_BIT_CLKERR = 7;
  localparam int IGM_BIT_LOCK = 6;
  localparam int IGM_LEVEL_LSB = 4;
  // pin function code that makes a pin a general input
  localparam logic [2:0] IGM_FUNC_GPI = 3'h1;
  // event-mode field values
  localparam logic [1:0] IGM_MODE_LEVEL = 2'h0;
  localparam logic [1:0] IGM_MODE_RSVD = 2'h1;
  localparam logic [1:0] IGM_MODE_REPEAT = 2'h2;
  localparam logic [1:0] IGM_MODE_ONCE = 2'h3;
  // timing
  localparam int IGM_CLK_PERIOD_NS = 4;
  localparam int IGM_PULSE_TIME_US = 2000;
  localparam int IGM_PERIOD_TIME_US = 4000;
  localparam int IGM_PULSE_CYCLES = IGM_PULSE_TIME_US * 1000 / IGM_CLK_PERIOD_NS;
  localparam int IGM_PERIOD_CYCLES = IGM_PERIOD_TIME_US * 1000 / IGM_CLK_PERIOD_NS;
  localparam int IGM_CNT_W = 21;
endpackage : igm_pkg

//--- rtl/igm_sync.sv
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level, not a bus that must stay coherent
module igm_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule // igm_sync

//--- rtl/igm_top.sv
// interrupt latch, mask and output shaping, plus general-input monitor
// assumes the register port and pin function fields come from same-clock logic
// Summary of operation
// (R1) Monitor bits 7..4 show pins 1..4 while each is a general input, bits 3..0 read zero.
// (R2) The host selects general-input use by writing function value 1 for a pin.
// (R3) The interrupt pin is active low with polarity 0 and active high with polarity 1.
// (R4) Mode 0 holds the interrupt active while any unmasked latched event pends; mode 1 is unused.
// (R5) Mode 2 asserts about 2 ms out of every 4 ms while an unmasked latched event pends.
// (R6) Mode 3 asserts once for about 2 ms on each new unmasked event.
// (R7) Readback select 0 shows all latched events, 1 shows only the unmasked ones.
// (R8) Mask bit 7, reset to 1, keeps the clock-error event off the interrupt.
// (R9) Mask bit 6, reset to 1, keeps the lock event off the interrupt.
// (R10) Latch bit 7 sets on a serial-port clock error and clears itself.
// (R11) Latch bit 6 sets when the pll gains lock and clears itself.
// (R12) The host leaves the six low mask bits at their reset value.
// (R13) A latch read clears the shown bits after returning them, unless the event persists.
module igm_top
  import igm_pkg::*;
#(
  parameter int PULSE_CYC = igm_pkg::IGM_PULSE_CYCLES,
  parameter int PERIOD_CYC = igm_pkg::IGM_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // pin function fields, same clock
  input wire logic [2:0] pin1_function_select_i,
  input wire logic [2:0] pin2_function_select_i,
  input wire logic [2:0] pin3_function_select_i,
  input wire logic [2:0] pin4_function_select_i,
  // general input pins, asynchronous
  input wire logic input1_level_i,
  input wire logic input2_level_i,
  input wire logic input3_level_i,
  input wire logic input4_level_i,
  // event sources, asynchronous levels
  input wire logic audio_serial_port_clk_error_i,
  input wire logic pll_locked_i,
  // interrupt pin
  output logic irq_active_low_o
);
  import igm_pkg::*;

  localparam logic [IGM_CNT_W-1:0] PULSE_C = IGM_CNT_W'(PULSE_CYC);
  localparam logic [IGM_CNT_W-1:0] PERIOD_LAST_C = IGM_CNT_W'(PERIOD_CYC - 1);
  localparam logic [IGM_CNT_W-1:0] CNT_ONE = IGM_CNT_W'(1);

  logic [5:0] sync_in;
  logic [5:0] sync_q;
  logic [3:0] gpi_s;
  logic clk_err_s;
  logic lock_s;
  logic clk_err_d;
  logic lock_d;
  logic irq_polarity;
  logic [1:0] event_mode;
  logic latch_readback_select;
  logic [7:0] event_mask_bits;
  logic [1:0] event_latch_bits;
  logic [IGM_CNT_W-1:0] tick;
  logic [IGM_CNT_W-1:0] next_tick;
  logic irq_active;

  assign sync_in = {audio_serial_port_clk_error_i, pll_locked_i,
                    input1_level_i, input2_level_i, input3_level_i, input4_level_i};

  igm_sync #(
    .W(6)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(sync_in),
    .sync_o(sync_q)
  );

  assign gpi_s = sync_q[3:0];
  assign lock_s = sync_q[4];
  assign clk_err_s = sync_q[5];

  // monitor: pin 1 lands in bit 7
  wire [3:0] level = {
    (pin1_function_select_i == IGM_FUNC_GPI) & gpi_s[3],
    (pin2_function_select_i == IGM_FUNC_GPI) & gpi_s[2],
    (pin3_function_select_i == IGM_FUNC_GPI) & gpi_s[1],
    (pin4_function_select_i == IGM_FUNC_GPI) & gpi_s[0]}; // R1
  wire [7:0] level_word = 8'(level) << IGM_LEVEL_LSB; // R1

  // events: index 1 clock error, index 0 lock
  wire lock_rise = lock_s & ~lock_d; // R11
  wire clk_err_rise = clk_err_s & ~clk_err_d;
  wire [1:0] ev_set = {clk_err_s, lock_rise}; // R10 R11
  wire [1:0] ev_occur = {clk_err_rise, lock_rise};
  wire [1:0] ev_mask = {event_mask_bits[IGM_BIT_CLKERR], event_mask_bits[IGM_BIT_LOCK]};
  wire [1:0] unmasked = event_latch_bits & ~ev_mask; // R8 R9
  wire pending = |unmasked;
  wire new_occ = |(ev_occur & ~ev_mask);
  wire [1:0] visible = latch_readback_select ? unmasked : event_latch_bits; // R7
  wire [7:0] latch_word = 8'(visible) << IGM_BIT_LOCK;
  wire [7:0] cfg_word = (8'(irq_polarity) << IGM_BIT_POL) |
                        (8'(event_mode) << IGM_BIT_MODE_LO) |
                        (8'(latch_readback_select) << IGM_BIT_RDSEL);

  // register decode
  wire sel_levels = reg_addr_i == IGM_ADDR_LEVELS;
  wire sel_cfg = reg_addr_i == IGM_ADDR_CFG;
  wire sel_mask = reg_addr_i == IGM_ADDR_MASK;
  wire sel_latch = reg_addr_i == IGM_ADDR_LATCH;
  wire wr_cfg = reg_wr_i & sel_cfg;
  wire wr_mask = reg_wr_i & sel_mask;
  wire rd_latch = reg_rd_i & sel_latch;
  wire [7:0] rd_value = sel_levels ? level_word :
                        sel_cfg ? cfg_word :
                        sel_mask ? event_mask_bits :
                        sel_latch ? latch_word : IGM_ZERO_WORD;
  // set wins over the read clear; hidden masked bits survive a read
  wire [1:0] clear_bits = rd_latch ? visible : 2'h0;
  wire [1:0] next_latch = (event_latch_bits & ~clear_bits) | ev_set; // R13

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_polarity <= 1'b0;
      event_mode <= IGM_MODE_LEVEL;
      latch_readback_select <= 1'b0;
    end else if (wr_cfg) begin
      irq_polarity <= reg_wdata_i[IGM_BIT_POL]; // R3
      event_mode <= reg_wdata_i[IGM_BIT_MODE_HI:IGM_BIT_MODE_LO];
      latch_readback_select <= reg_wdata_i[IGM_BIT_RDSEL];
    end
  end

  // reserved low bits are kept writable as stored bits
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_mask_bits <= IGM_MASK_RESET; // R8 R9
    end else if (wr_mask) begin
      event_mask_bits <= reg_wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_latch_bits <= 2'h0;
      clk_err_d <= 1'b0;
      lock_d <= 1'b0;
    end else begin
      event_latch_bits <= next_latch; // R10 R11 R13
      clk_err_d <= clk_err_s;
      lock_d <= lock_s;
    end
  end

  // read data is taken before the clear lands
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= IGM_ZERO_WORD;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_value;
    end
  end

  // one counter serves both timed modes; a change between them carries the count over while an event pends; modes 0 and 1, and mode 2 with nothing pending, clear it
  always_comb begin
    next_tick = '0;
    case (event_mode)
      IGM_MODE_REPEAT: begin
        if (pending && tick != PERIOD_LAST_C) begin
          next_tick = tick + CNT_ONE; // R5
        end
      end
      IGM_MODE_ONCE: begin
        if (new_occ) begin
          next_tick = PULSE_C; // R6
        end else if (tick != '0) begin
          next_tick = tick - CNT_ONE;
        end
      end
      default: next_tick = '0;
    endcase
  end

  always_comb begin
    irq_active = 1'b0;
    case (event_mode)
      IGM_MODE_LEVEL: irq_active = pending; // R4
      IGM_MODE_REPEAT: irq_active = pending && (tick < PULSE_C); // R5
      IGM_MODE_ONCE: irq_active = tick != '0; // R6
      default: irq_active = 1'b0; // R4
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick <= '0;
      irq_active_low_o <= 1'b1;
    end else begin
      tick <= next_tick;
      irq_active_low_o <= irq_polarity ? irq_active : ~irq_active; // R3
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_once_load;
    event_mode == IGM_MODE_ONCE && new_occ;
  endsequence

  sequence s_once_pulse;
    tick == PULSE_C ##1 irq_active;
  endsequence

  AST_LEVEL_LOW_ZERO: assert property (reg_rd_i && sel_levels |=> reg_rdata_o[3:0] == 4'h0) // R1
    else $error("monitor low bits not zero");
  AST_LEVEL_PIN1: assert property (reg_rd_i && sel_levels &&
      pin1_function_select_i == IGM_FUNC_GPI |=> reg_rdata_o[7] == $past(gpi_s[3])) // R1
    else $error("pin 1 level not shown in bit 7");
  AST_POL_LOW: assert property (event_mode == IGM_MODE_LEVEL && !irq_polarity &&
      pending |=> !irq_active_low_o) // R3
    else $error("active-low interrupt not low");
  AST_LEVEL_MODE: assert property (event_mode == IGM_MODE_LEVEL && pending |=>
      irq_active_low_o == $past(irq_polarity)) // R4
    else $error("level mode not asserted while pending");
  AST_RSVD_IDLE: assert property (event_mode == IGM_MODE_RSVD |=>
      irq_active_low_o == !$past(irq_polarity)) // R4
    else $error("reserved mode drove interrupt");
  AST_REPEAT_OFF: assert property (event_mode == IGM_MODE_REPEAT && pending &&
      tick == PULSE_C |-> !irq_active) // R5
    else $error("repeat pulse too long");
  AST_REPEAT_WRAP: assert property (event_mode == IGM_MODE_REPEAT && pending &&
      tick == PERIOD_LAST_C ##1 event_mode == IGM_MODE_REPEAT && pending |-> irq_active) // R5
    else $error("repeat period did not restart");
  AST_ONCE_PULSE: assert property (s_once_load ##1 event_mode == IGM_MODE_ONCE |->
      s_once_pulse) // R6
    else $error("single pulse not started");
  AST_RDSEL_HIDE: assert property (rd_latch && latch_readback_select |=>
      (reg_rdata_o[7:6] & $past(ev_mask)) == 2'h0) // R7
    else $error("masked event visible");
  // mask fields taken from the stored register, so a wrong field pick shows up
  AST_MASK_CLKERR: assert property (event_mask_bits[IGM_BIT_CLKERR] &&
      !event_latch_bits[0] |-> !pending) // R8
    else $error("masked clock error pends");
  AST_MASK_LOCK: assert property (event_mask_bits[IGM_BIT_LOCK] &&
      !event_latch_bits[1] |-> !pending) // R9
    else $error("masked lock event pends");
  AST_SET_CLKERR: assert property (clk_err_s |=> event_latch_bits[1]) // R10
    else $error("clock error not latched");
  AST_SET_LOCK: assert property ($rose(lock_s) |=> event_latch_bits[0]) // R11
    else $error("lock not latched");
  AST_READ_CLEAR: assert property (rd_latch && !latch_readback_select && ev_set == 2'h0 |=>
      event_latch_bits == 2'h0 && reg_rdata_o[7:6] == $past(event_latch_bits)) // R13
    else $error("latch read did not clear");
endmodule // igm_top

//--- bench/igm_host_model.sv
// host-side model: pin function fields and an interrupt pin watcher
// assumes the host runs on the block's own system clock
module igm_host_model (
  // clock
  input wire logic ref_clk_i,
  // bench control
  input wire logic [3:0] gpi_enable_i,
  input wire logic polarity_i,
  input wire logic count_clr_i,
  // interrupt pin
  input wire logic irq_pin_i,
  // pin function fields
  output logic [2:0] pin1_function_select_o,
  output logic [2:0] pin2_function_select_o,
  output logic [2:0] pin3_function_select_o,
  output logic [2:0] pin4_function_select_o,
  // observation
  output logic irq_on_o,
  output logic [15:0] irq_cycles_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import igm_pkg::*;
  assign pin1_function_select_o = gpi_enable_i[3] ? IGM_FUNC_GPI : 3'h0;
  assign pin2_function_select_o = gpi_enable_i[2] ? IGM_FUNC_GPI : 3'h0;
  assign pin3_function_select_o = gpi_enable_i[1] ? IGM_FUNC_GPI : 3'h0;
  assign pin4_function_select_o = gpi_enable_i[0] ? IGM_FUNC_GPI : 3'h0;
  // host must know the programmed polarity to judge the pin
  assign irq_on_o = polarity_i ? irq_pin_i : ~irq_pin_i;
  always_ff @(posedge ref_clk_i) begin
    if (count_clr_i) begin
      irq_cycles_o <= 16'h0;
    end else if (irq_on_o) begin
      irq_cycles_o <= irq_cycles_o + 16'h1;
    end
  end
endmodule // igm_host_model

//--- bench/test_irq_and_gpi_monitor.sv
// self-checking bench for the interrupt and general-input monitor
// assumes short pulse counts (4 of 8) so the shaped modes finish quickly
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module test_irq_and_gpi_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  import igm_pkg::*;
  localparam int P_PULSE = 4;
  localparam int P_PERIOD = 8;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [2:0] fs1, fs2, fs3, fs4;
  logic [3:0] lv = 4'h0;
  logic [3:0] gpi_en = 4'h0;
  logic clk_err = 1'b0;
  logic pll = 1'b0;
  logic pol = 1'b0;
  logic cnt_clr = 1'b1;
  logic irq_pin;
  logic irq_on;
  logic [15:0] irq_cycles;
  int n_fail = 0;
  int checked = 0;

  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end

  igm_top #(.PULSE_CYC(P_PULSE), .PERIOD_CYC(P_PERIOD)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .pin1_function_select_i(fs1), .pin2_function_select_i(fs2),
    .pin3_function_select_i(fs3), .pin4_function_select_i(fs4),
    .input1_level_i(lv[3]), .input2_level_i(lv[2]),
    .input3_level_i(lv[1]), .input4_level_i(lv[0]),
    .audio_serial_port_clk_error_i(clk_err), .pll_locked_i(pll),
    .irq_active_low_o(irq_pin));

  igm_host_model i_host (
    .ref_clk_i(ref_clk_i), .gpi_enable_i(gpi_en), .polarity_i(pol),
    .count_clr_i(cnt_clr), .irq_pin_i(irq_pin),
    .pin1_function_select_o(fs1), .pin2_function_select_o(fs2),
    .pin3_function_select_o(fs3), .pin4_function_select_o(fs4),
    .irq_on_o(irq_on), .irq_cycles_o(irq_cycles));

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    reg_addr_i = addr;
    reg_wdata_i = data;
    reg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    reg_wr_i = 1'b0;
    // idle cycle so a following call never re-raises the strobe in the same step
    @(negedge ref_clk_i);
  endtask

  // read data is registered, so it is settled by the following falling edge
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    reg_addr_i = addr;
    reg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    reg_rd_i = 1'b0;
    `CHK(reg_rdata_o, exp)
    @(negedge ref_clk_i);
  endtask

  task automatic measure(input int n);
    cnt_clr = 1'b1;
    wait_cyc(1);
    cnt_clr = 1'b0;
    wait_cyc(n);
  endtask

  task automatic done(input string name);
    $display("test %s ended", name);
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    tally_and_finish;
  end

  initial begin
    wait_cyc(20);
    rst_n_i = 1'b1;
    rd(IGM_ADDR_LEVELS, 8'h00);
    rd(IGM_ADDR_CFG, 8'h00);
    rd(IGM_ADDR_MASK, 8'hff);
    rd(IGM_ADDR_LATCH, 8'h00);
    rd(8'h40, 8'h00);
    `CHK(irq_on, 1'b0)
    done("reset");
    wr(IGM_ADDR_CFG, 8'hff);
    rd(IGM_ADDR_CFG, 8'he4);
    wr(IGM_ADDR_LATCH, 8'hff);
    rd(IGM_ADDR_LATCH, 8'h00);
    wr(IGM_ADDR_CFG, 8'h00);
    done("config");
    gpi_en = 4'hf;
    lv = 4'hb;
    wait_cyc(4);
    rd(IGM_ADDR_LEVELS, 8'hb0);
    lv = 4'h4;
    wait_cyc(4);
    rd(IGM_ADDR_LEVELS, 8'h40);
    done("monitor");
    pll = 1'b1;
    wait_cyc(5);
    `CHK(irq_on, 1'b0)
    rd(IGM_ADDR_LATCH, 8'h40);
    rd(IGM_ADDR_LATCH, 8'h00);
    clk_err = 1'b1;
    wait_cyc(5);
    clk_err = 1'b0;
    wait_cyc(4);
    `CHK(irq_on, 1'b0)
    rd(IGM_ADDR_LATCH, 8'h80);
    rd(IGM_ADDR_LATCH, 8'h00);
    done("masked");
    wr(IGM_ADDR_CFG, 8'h04);
    pll = 1'b0;
    wait_cyc(3);
    pll = 1'b1;
    wait_cyc(5);
    rd(IGM_ADDR_LATCH, 8'h00);
    wr(IGM_ADDR_MASK, 8'hbf);
    wait_cyc(3);
    `CHK(irq_on, 1'b1)
    rd(IGM_ADDR_LATCH, 8'h40);
    wait_cyc(3);
    `CHK(irq_on, 1'b0)
    done("level");
    wr(IGM_ADDR_MASK, 8'h3f);
    clk_err = 1'b1;
    wr(IGM_ADDR_CFG, 8'h80);
    pol = 1'b1;
    wait_cyc(5);
    `CHK(irq_pin, 1'b1)
    rd(IGM_ADDR_LATCH, 8'h80);
    rd(IGM_ADDR_LATCH, 8'h80);
    wr(IGM_ADDR_CFG, 8'ha0);
    wait_cyc(3);
    `CHK(irq_pin, 1'b0)
    wr(IGM_ADDR_CFG, 8'hc0);
    wait_cyc(4);
    measure(2 * P_PERIOD);
    `CHK(irq_cycles, 16'(2 * P_PULSE))
    done("repeat");
    clk_err = 1'b0;
    wait_cyc(4);
    rd(IGM_ADDR_LATCH, 8'h80);
    wr(IGM_ADDR_CFG, 8'he0);
    pll = 1'b0;
    wait_cyc(3);
    measure(1);
    pll = 1'b1;
    wait_cyc(5 * P_PERIOD);
    `CHK(irq_cycles, 16'(P_PULSE))
    done("pulse");
    tally_and_finish;
  end
endmodule // test_irq_and_gpi_monitor
